// *** asr_ctrl.sv ***
// Host controller for an asynchronous 1M x 16 static memory.
// Assumes requests come from logic on mclk_i; the data bus pins come
// from outside and are synchronised before use.
`timescale 1ns/1ps
module asr_ctrl
(
    input  wire logic                          mclk_i,
    input  wire logic                          rst_b_i,
    input  wire logic                          ce_i,
    input  wire logic                          req_i,
    input  wire logic                          req_write_i,
    input  wire logic [asr_pkg::ADDR_W-1:0]    req_addr_i,
    input  wire logic [asr_pkg::DATA_W-1:0]    req_wdata_i,
    input  wire logic [1:0]                    req_lanes_i,
    input  wire logic                          retain_i,
    output logic                               busy_o,
    output logic                               rdata_valid_o,
    output logic [asr_pkg::DATA_W-1:0]         rdata_o,
    output logic                               retain_ready_o,
    output logic [asr_pkg::ADDR_W-1:0]         word_address_bus_o,
    input  wire logic [asr_pkg::DATA_W-1:0]    shared_data_bus_i,
    output logic [asr_pkg::DATA_W-1:0]         shared_data_bus_o,
    output logic                               shared_data_bus_oe_o,
    output logic                               select_low_active_o,
    output logic                               select_high_active_o,
    output logic                               write_strobe_low_o,
    output logic                               output_enable_low_o,
    output logic                               lower_lane_select_low_o,
    output logic                               upper_lane_select_low_o
);
    import asr_pkg::*;

    asr_tmr_if  tif ();
    asr_state_t state_q;
    asr_state_t state_d;
    logic [DATA_W-1:0] din_meta_q;
    logic [DATA_W-1:0] din_sync_q;
    logic              is_wr_q;
    logic              tmr_load;
    logic [2:0]        tmr_count;

    asr_timer u_timer
    (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .tmr     (tif.tmr)
    );

    assign tif.load  = tmr_load;
    assign tif.count = tmr_count;

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            din_meta_q <= '0;
            din_sync_q <= '0;
        end
        else if (ce_i)
        begin
            din_meta_q <= shared_data_bus_i;
            din_sync_q <= din_meta_q;
        end
    end

    always_comb
    begin
        state_d   = state_q;
        tmr_load  = 1'b0;
        tmr_count = CNT_ZERO;
        case (state_q)
            ASR_IDLE:
            begin
                if (retain_i)
                    state_d = ASR_RETAIN;
                else if (req_i)
                begin
                    // Address goes out one phase before the strobe.
                    state_d   = req_write_i ? ASR_SETUP : ASR_READ;
                    tmr_load  = 1'b1;
                    tmr_count = req_write_i ? 3'(ADDR_SET_CYC - 1)
                                            : 3'(ACCESS_CYC + 1);
                end
            end
            ASR_SETUP:
            begin
                if (tif.done)
                begin
                    // Strobe low for the full write interval.
                    state_d   = ASR_STROBE;
                    tmr_load  = 1'b1;
                    tmr_count = 3'(STROBE_CYC - 1);
                end
            end
            ASR_STROBE:
            begin
                if (tif.done)
                begin
                    // Recovery phase pads the cycle out.
                    state_d   = ASR_RECOV;
                    tmr_load  = 1'b1;
                    tmr_count = 3'(WR_REC_CYC - 1);
                end
            end
            ASR_READ, ASR_RECOV:
            begin
                if (tif.done)
                    state_d = ASR_IDLE;
            end
            ASR_RETAIN:
            begin
                if (!retain_i)
                    state_d = ASR_IDLE;
            end
            default:
                state_d = ASR_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            state_q <= ASR_IDLE;
        else if (ce_i)
            state_q <= state_d;
    end

    // Requests are latched at acceptance; the pins then stay steady.
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            word_address_bus_o      <= '0;
            shared_data_bus_o       <= '0;
            is_wr_q                 <= 1'b0;
            lower_lane_select_low_o <= 1'b1;
            upper_lane_select_low_o <= 1'b1;
        end
        else if (ce_i && state_q == ASR_IDLE && req_i && !retain_i)
        begin
            // Address held until back in idle.
            word_address_bus_o      <= req_addr_i;
            shared_data_bus_o       <= req_wdata_i;
            is_wr_q                 <= req_write_i;
            // Bit 0 is the lower lane, bit 1 the upper.
            lower_lane_select_low_o <= !req_lanes_i[0];
            upper_lane_select_low_o <= !req_lanes_i[1];
        end
    end

    // Select pins follow the next state so they change with the FSM.
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            select_low_active_o  <= 1'b1;
            select_high_active_o <= 1'b0;
            write_strobe_low_o   <= 1'b1;
            output_enable_low_o  <= 1'b1;
            shared_data_bus_oe_o <= 1'b0;
            busy_o               <= 1'b0;
            retain_ready_o       <= 1'b0;
        end
        else if (ce_i)
        begin
            // Both selects active through any access.
            select_low_active_o  <= !(state_d inside {ASR_SETUP,
                                      ASR_STROBE, ASR_RECOV, ASR_READ});
            // Low high select alone holds retention.
            // High select driven solidly low in retention.
            select_high_active_o <= state_d inside {ASR_SETUP,
                                      ASR_STROBE, ASR_RECOV, ASR_READ};
            // Strobe is the last control to assert.
            // Strobe is the first control to deassert.
            write_strobe_low_o   <= !(state_d == ASR_STROBE);
            output_enable_low_o  <= !(state_d == ASR_READ);
            shared_data_bus_oe_o <= state_d inside {ASR_SETUP,
                                      ASR_STROBE, ASR_RECOV};
            busy_o               <= state_d != ASR_IDLE;
            retain_ready_o       <= state_d == ASR_RETAIN;
        end
    end

    // Read data sampled at the end of the read phase.
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rdata_o       <= '0;
            rdata_valid_o <= 1'b0;
        end
        else if (ce_i)
        begin
            rdata_valid_o <= state_q == ASR_READ && tif.done;
            if (state_q == ASR_READ && tif.done)
                rdata_o <= din_sync_q;
        end
    end

    a_strobe_width: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        $fell(write_strobe_low_o) |->
            !write_strobe_low_o [*2])
        else $error("write strobe shorter than interval");

    a_write_selects: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        !write_strobe_low_o |-> !select_low_active_o && select_high_active_o
            && is_wr_q
            && !(lower_lane_select_low_o && upper_lane_select_low_o))
        else $error("strobe low without selects");

    a_select_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        $rose(write_strobe_low_o) |-> $past(select_high_active_o, 3)
            && !$past(select_low_active_o, 3))
        else $error("select window too short before write end");

    a_addr_stable: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        !select_low_active_o && $past(!select_low_active_o)
            |-> $stable(word_address_bus_o))
        else $error("address moved during access");

    a_bus_no_clash: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        !(shared_data_bus_oe_o && !output_enable_low_o))
        else $error("host drives bus during read");

    sequence s_read_start;
        $fell(output_enable_low_o);
    endsequence
    a_read_length: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        s_read_start |-> !output_enable_low_o [*2])
        else $error("read shorter than access time");

    a_retain_desel: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        retain_ready_o |-> select_low_active_o && !select_high_active_o)
        else $error("selected while in retention");

    a_strobe_first: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        $rose(write_strobe_low_o) |-> !select_low_active_o)
        else $error("select dropped before strobe");

endmodule : asr_ctrl

// *** asr_ctrl_tb_top.sv ***
// Self-checking bench for the static memory host controller.
// Assumes the design files and the memory model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    mismatches++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module asr_ctrl_tb_top;
    import asr_pkg::*;
    logic              mclk_i = 1'b0;
    logic              rst_b_i = 1'b0;
    logic              ce_i = 1'b1;
    logic              req_i = 1'b0;
    logic              req_write_i = 1'b0;
    logic [ADDR_W-1:0] req_addr_i = 20'h0;
    logic [DATA_W-1:0] req_wdata_i = 16'h0;
    logic [1:0]        req_lanes_i = 2'h3;
    logic              retain_i = 1'b0;
    logic              busy_o, rdata_valid_o, retain_ready_o;
    logic [DATA_W-1:0] rdata_o, shared_data_bus_o, shared_data_bus_i;
    logic [ADDR_W-1:0] word_address_bus_o;
    logic              shared_data_bus_oe_o, write_strobe_low_o;
    logic              select_low_active_o, select_high_active_o;
    logic              output_enable_low_o, lower_lane_select_low_o;
    logic              upper_lane_select_low_o;
    logic [DATA_W-1:0] dev_q;
    logic [DATA_W-1:0] last_q = 16'h0;
    logic [1:0]        dev_oe;
    int                errs;
    int                mismatches = 0;
    int                n_compared = 0;

    always #(CLK_PERIOD_NS / 2) mclk_i = ~mclk_i;

    // A released lane shows a pattern that flips every cycle.
    always @(posedge mclk_i) last_q <= shared_data_bus_i;
    always_comb
    begin
        shared_data_bus_i = ~last_q;
        if (dev_oe[0]) shared_data_bus_i[7:0] = dev_q[7:0];
        if (dev_oe[1]) shared_data_bus_i[15:8] = dev_q[15:8];
        if (shared_data_bus_oe_o) shared_data_bus_i = shared_data_bus_o;
    end

    asr_ctrl u_dut (
        .mclk_i                  (mclk_i),
        .rst_b_i                 (rst_b_i),
        .ce_i                    (ce_i),
        .req_i                   (req_i),
        .req_write_i             (req_write_i),
        .req_addr_i              (req_addr_i),
        .req_wdata_i             (req_wdata_i),
        .req_lanes_i             (req_lanes_i),
        .retain_i                (retain_i),
        .busy_o                  (busy_o),
        .rdata_valid_o           (rdata_valid_o),
        .rdata_o                 (rdata_o),
        .retain_ready_o          (retain_ready_o),
        .word_address_bus_o      (word_address_bus_o),
        .shared_data_bus_i       (shared_data_bus_i),
        .shared_data_bus_o       (shared_data_bus_o),
        .shared_data_bus_oe_o    (shared_data_bus_oe_o),
        .select_low_active_o     (select_low_active_o),
        .select_high_active_o    (select_high_active_o),
        .write_strobe_low_o      (write_strobe_low_o),
        .output_enable_low_o     (output_enable_low_o),
        .lower_lane_select_low_o (lower_lane_select_low_o),
        .upper_lane_select_low_o (upper_lane_select_low_o)
    );
    asr_sram_model u_mem (
        .select_low_active_i  (select_low_active_o),
        .select_high_active_i (select_high_active_o),
        .write_strobe_low_i   (write_strobe_low_o),
        .output_enable_low_i  (output_enable_low_o),
        .lane_low_i  ({upper_lane_select_low_o, lower_lane_select_low_o}),
        .addr_i      (word_address_bus_o),
        .dq_i        (shared_data_bus_i),
        .dq_o        (dev_q),
        .dq_oe_o     (dev_oe),
        .errs_o      (errs)
    );

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic access(input logic wr, input logic [19:0] a,
                          input logic [15:0] d, input logic [1:0] ln,
                          output logic [15:0] q, output int cyc);
        int         stb;
        logic [1:0] lns;
        logic [1:0] sel;
        cyc = 0;
        stb = 0;
        @(posedge mclk_i);
        req_i <= 1'b1;
        req_write_i <= wr;
        req_addr_i <= a;
        req_wdata_i <= d;
        req_lanes_i <= ln;
        @(posedge mclk_i);
        req_i <= 1'b0;
        do
        begin
            @(posedge mclk_i);
            #1;
            cyc++;
            if (write_strobe_low_o === 1'b0)
            begin
                stb++;
                lns = {upper_lane_select_low_o, lower_lane_select_low_o};
                sel = {select_high_active_o, select_low_active_o};
                `CHK("lanes", ~ln, lns)
                `CHK("sel", 2'h2, sel)
                `CHK("wdata", d, shared_data_bus_i)
                `CHK("addr", a, word_address_bus_o)
            end
        end
        while (cyc < 20 && (wr ? busy_o !== 1'b0 : rdata_valid_o !== 1'b1));
        q = rdata_o;
        `CHK("strobe cycles", wr ? STROBE_CYC : 0, stb)
        if (cyc >= 20)
        begin
            mismatches++;
            end_sim();
        end
    endtask : access

    task automatic t_reset();
        logic [7:0] pins;
        pins = {busy_o, shared_data_bus_oe_o, select_low_active_o,
                select_high_active_o, write_strobe_low_o,
                output_enable_low_o, lower_lane_select_low_o,
                upper_lane_select_low_o};
        `CHK("reset pins", 8'h2F, pins)
        `CHK("reset addr", 20'h0, word_address_bus_o)
    endtask : t_reset

    task automatic t_word();
        logic [15:0] q;
        int          c;
        access(1'b1, 20'h00000, 16'hA55A, 2'h3, q, c);
        // Setup, strobe and recovery phases, each its own count.
        `CHK("wr cycles", ADDR_SET_CYC + STROBE_CYC + WR_REC_CYC, c)
        access(1'b1, 20'hFFFFF, 16'h5AA5, 2'h3, q, c);
        access(1'b0, 20'h00000, 16'h0000, 2'h3, q, c);
        // The access time plus the two data synchroniser flops.
        `CHK("rd cycles", ACCESS_CYC + 2, c)
        `CHK("rd first", 16'hA55A, q)
        access(1'b0, 20'hFFFFF, 16'h0000, 2'h3, q, c);
        `CHK("rd last", 16'h5AA5, q)
    endtask : t_word

    task automatic t_lanes();
        logic [15:0] q;
        int          c;
        access(1'b1, 20'h12345, 16'h1234, 2'h3, q, c);
        access(1'b1, 20'h12345, 16'hFFCD, 2'h1, q, c);
        access(1'b1, 20'h12345, 16'h56FF, 2'h2, q, c);
        access(1'b0, 20'h12345, 16'h0000, 2'h3, q, c);
        `CHK("merged", 16'h56CD, q)
        access(1'b0, 20'h12345, 16'h0000, 2'h1, q, c);
        `CHK("low lane", 8'hCD, q[7:0])
        access(1'b0, 20'h12345, 16'h0000, 2'h2, q, c);
        `CHK("up lane", 8'h56, q[15:8])
    endtask : t_lanes

    task automatic t_refuse();
        logic [15:0] q;
        int          c;
        @(posedge mclk_i);
        req_i <= 1'b1;
        req_write_i <= 1'b1;
        req_addr_i <= 20'h00777;
        req_wdata_i <= 16'hDEAD;
        req_lanes_i <= 2'h3;
        @(posedge mclk_i);
        req_wdata_i <= 16'hBEEF;
        repeat (2) @(posedge mclk_i);
        req_i <= 1'b0;
        for (int i = 0; i < 10 && busy_o !== 1'b0; i++)
        begin
            @(posedge mclk_i);
            #1;
        end
        `CHK("idle", 1'b0, busy_o)
        if (busy_o !== 1'b0)
            end_sim();
        access(1'b0, 20'h00777, 16'h0000, 2'h3, q, c);
        `CHK("refused", 16'hDEAD, q)
    endtask : t_refuse

    // A request made while the clock enable is low must not be taken.
    task automatic t_freeze();
        @(posedge mclk_i);
        ce_i <= 1'b0;
        req_i <= 1'b1;
        req_write_i <= 1'b1;
        req_addr_i <= 20'h00000;
        req_wdata_i <= 16'h0BAD;
        req_lanes_i <= 2'h3;
        repeat (3) @(posedge mclk_i);
        #1;
        `CHK("frozen", 1'b0, busy_o)
        @(posedge mclk_i);
        req_i <= 1'b0;
        ce_i <= 1'b1;
    endtask : t_freeze

    task automatic t_retain();
        logic [15:0] q;
        int          c;
        logic [3:0]  pins;
        @(posedge mclk_i);
        retain_i <= 1'b1;
        req_i <= 1'b1;
        req_write_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        #1;
        pins = {retain_ready_o, busy_o, select_low_active_o,
                select_high_active_o};
        // Busy stays high while retention holds the memory deselected.
        `CHK("retain pins", 4'hE, pins)
        @(posedge mclk_i);
        retain_i <= 1'b0;
        req_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        `CHK("left retain", 1'b0, retain_ready_o)
        access(1'b0, 20'h00000, 16'h0000, 2'h3, q, c);
        `CHK("kept", 16'hA55A, q)
    endtask : t_retain

    initial
    begin
        repeat (12) @(posedge mclk_i);
        t_reset();
        rst_b_i <= 1'b1;
        t_word();
        t_lanes();
        t_refuse();
        t_freeze();
        t_retain();
        `CHK("model errors", 0, errs)
        end_sim();
    end
endmodule : asr_ctrl_tb_top

// *** asr_pkg.sv ***
// Package for the asynchronous SRAM host controller: pin widths, timing
// figures in nanoseconds and their cycle counts at the system clock.
// Assumes a 25 MHz system clock feeding the controller.
package asr_pkg;

    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned ADDR_W        = 20;
    localparam int unsigned DATA_W        = 16;
    localparam int unsigned LANE_W        = 8;

    // Slower grade figures; the faster grade is covered by them.
    localparam int unsigned ACCESS_NS               = 55;
    localparam int unsigned WRITE_INTERVAL_MIN_NS   = 40;
    localparam int unsigned SELECT_TO_WR_END_MIN_NS = 50;
    localparam int unsigned ADDR_BEFORE_WR_MIN_NS   = 0;
    localparam int unsigned WRITE_RECOVERY_MIN_NS   = 0;
    localparam int unsigned DESELECT_BEFORE_RET_NS  = 0;

    function automatic int unsigned ns_to_cyc(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc

    localparam int unsigned ACCESS_CYC   = ns_to_cyc(ACCESS_NS);
    localparam int unsigned WR_INT_CYC   = ns_to_cyc(WRITE_INTERVAL_MIN_NS);
    localparam int unsigned SEL_WR_CYC   = ns_to_cyc(SELECT_TO_WR_END_MIN_NS);
    localparam int unsigned ADDR_SET_CYC = ns_to_cyc(ADDR_BEFORE_WR_MIN_NS);
    localparam int unsigned WR_REC_CYC   = ns_to_cyc(WRITE_RECOVERY_MIN_NS);
    localparam int unsigned RET_CYC      = ns_to_cyc(DESELECT_BEFORE_RET_NS);
    // Strobe low time covers both the write interval and select window.
    localparam int unsigned STROBE_CYC   =
        (WR_INT_CYC > SEL_WR_CYC) ? WR_INT_CYC : SEL_WR_CYC;

    localparam logic [2:0] CNT_ZERO = 3'h0;

    typedef enum logic [5:0] {
        ASR_IDLE   = 6'h01,
        ASR_SETUP  = 6'h02,
        ASR_STROBE = 6'h04,
        ASR_RECOV  = 6'h08,
        ASR_READ   = 6'h10,
        ASR_RETAIN = 6'h20
    } asr_state_t;

endpackage : asr_pkg

// *** asr_sram_model.sv ***
// Behavioural model of the 1M x 16 static memory behind the controller.
// Assumes the bench resolves the shared data bus and feeds it to dq_i.
`timescale 1ns/1ps
module asr_sram_model
#(
    parameter int unsigned DLY_NS = asr_pkg::ACCESS_NS
)
(
    input  wire logic                       select_low_active_i,
    input  wire logic                       select_high_active_i,
    input  wire logic                       write_strobe_low_i,
    input  wire logic                       output_enable_low_i,
    input  wire logic [1:0]                 lane_low_i,
    input  wire logic [asr_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [asr_pkg::DATA_W-1:0] dq_i,
    output logic      [asr_pkg::DATA_W-1:0] dq_o,
    output logic      [1:0]                 dq_oe_o,
    output int                              errs_o
);
    import asr_pkg::*;
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic              sel;
    logic              rd;
    wire               rd_late;
    logic [1:0]        wr;
    logic [1:0]        wr_ln = 2'h0;
    realtime           t_wr;
    realtime           t_sel;
    int                e_wr = 0;
    int                e_addr = 0;
    int                e_lvl = 0;
    // Each checking process keeps its own count so that every counter has one writer.
    assign errs_o = e_wr + e_addr + e_lvl;
    assign sel = !select_low_active_i && select_high_active_i;
    assign wr = {2{sel && !write_strobe_low_i}} & ~lane_low_i;
    assign rd = sel && write_strobe_low_i && !output_enable_low_i;
    assign #(DLY_NS) rd_late = rd;
    assign dq_oe_o = {2{rd && rd_late}} & ~lane_low_i;
    // Unwritten words read back as the inverted low 16 bits of their address.
    always @(addr_i, rd)
        dq_o = mem.exists(addr_i) ? mem[addr_i] : ~addr_i[15:0];
    always @(posedge (|wr)) t_wr = $realtime;
    always @(posedge sel) t_sel = $realtime;
    always @(wr) if (|wr) wr_ln = wr;
    always @(negedge (|wr))
    begin
        if (wr_ln != 2'h0)
        begin
            if ($realtime - t_wr < WRITE_INTERVAL_MIN_NS) e_wr++;
            if ($realtime - t_sel < SELECT_TO_WR_END_MIN_NS) e_wr++;
            if (!mem.exists(addr_i)) mem[addr_i] = ~addr_i[15:0];
            if (wr_ln[0]) mem[addr_i][7:0] = dq_i[7:0];
            if (wr_ln[1]) mem[addr_i][15:8] = dq_i[15:8];
        end
    end
    always @(addr_i) if (|wr) e_addr++;
    always @(select_high_active_i)
        if ($isunknown(select_high_active_i)) e_lvl++;
endmodule : asr_sram_model

// *** asr_timer.sv ***
// Down counter that times each phase of a memory access.
// Assumes load is a one-cycle pulse from the sequencer.
`timescale 1ns/1ps
module asr_timer
(
    input  wire logic mclk_i,
    input  wire logic rst_b_i,
    input  wire logic ce_i,
    asr_tmr_if.tmr    tmr
);
    import asr_pkg::*;

    logic [2:0] cnt_q;

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cnt_q <= CNT_ZERO;
        else if (ce_i)
        begin
            if (tmr.load)
                cnt_q <= tmr.count;
            else if (cnt_q != CNT_ZERO)
                cnt_q <= cnt_q - 3'h1;
        end
    end

    // Done looks at the count only. Gating it by load would close a
    // combinational loop through the sequencer, which loads on done.
    assign tmr.done = (cnt_q == CNT_ZERO);

endmodule : asr_timer

// *** asr_tmr_if.sv ***
// Interface between the controller sequencer and its cycle timer.
// Assumes both sides share the controller clock.
`timescale 1ns/1ps
interface asr_tmr_if;
    logic       load;
    logic [2:0] count;
    logic       done;
    modport seq (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface : asr_tmr_if
